// ===== src/tx_err_map.svh
// Purpose: Register offsets, field positions and counts of the transmit error insert block.
// Assumes: Byte addresses on a 32-bit classic Wishbone bus.
// Notes:   Definitions only.
`ifndef TX_ERR_MAP_SVH
`define TX_ERR_MAP_SVH
`define ADR_FRAMER_CTRL   8'h10
`define ADR_ERR_INSERT    8'h18
`define ADR_LINE_CFG      8'h1C
`define ADR_INSERT_STATUS 8'h20
`define AUTO_BLOCK_ERROR_DEFEAT_BIT        12
`define FORCED_BLOCK_ERROR_SETTING_BIT         13
`define PLB_BIT           14
`define BPV_BIT           0
`define EXZ_BIT           1
`define PBIT_BIT          2
`define CPBIT_BIT         3
`define FBE_BIT           4
`define FTYPE_LSB_BIT     5
`define FTYPE_MSB_BIT     6
`define MANUAL_BIT        7
`define CFG_E3_BIT        0
`define CFG_CBIT_BIT      1
`define CFG_UNIPOLAR_BIT  2
`define FAS_FIRST_IDX     4'h0
`define FAS_SINGLE_IDX    4'h5
`define FAS_LAST_IDX      4'h9
`define FE_COUNT_ONE      3'h1
`define FE_COUNT_F_BURST  3'h4
`define FE_COUNT_M_BURST  3'h3
`define FE_COUNT_E3_BURST 3'h4
`define ONES_BEFORE_BPV   2'h2
`define WORD_ZERO         32'h0000_0000
`endif

// ===== src/tx_err_pkg.sv
// Purpose: Types shared by the transmit error insert block and its bench.
// Assumes: Nothing beyond the map header.
// Notes:   Field order is the packing order.
package tx_err_pkg;
   typedef struct packed {
      logic       data;         // Formatter bit
      logic       rx_data;      // Framed receive bit for payload loopback
      logic       subst_ok;     // Encoder would place a substitution codeword here
      logic       f_bit;        // T3 F-bit position
      logic       m_bit;        // T3 M-bit position
      logic       p_bit;        // T3 P-bit position
      logic       cp_bit;       // T3 CP-bit position
      logic       febe_bit;     // T3 subframe 4 C-bit position
      logic       fas_bit;      // E3 alignment word position
      logic [3:0] fas_idx;      // E3 alignment bit index, 0 first
      logic       frame_start;  // First bit of a frame
      logic       rx_block_err; // Receive side found a block error
   } fmt_in_t;
   typedef struct packed {
      logic data;     // Line bit after error insertion
      logic bpv;      // Encoder shall send this mark as a violation
      logic no_subst; // Encoder shall skip the codeword here
      logic valid;    // One-cycle strobe per line bit
   } line_out_t;
endpackage

// ===== src/t3e3_tx_error_insert.sv
// Purpose: Transmit error insertion, block error code and payload loopback select.
// Assumes: Line clock, manual pin and formatter signals are asynchronous and pass two flip-flops.
// Notes:   Wishbone classic slave; every access is answered one cycle after it starts.
// Summary of operation
// R1 - Auto mode sends block error code from receive errors
// R2 - Defeat set takes code from forced setting
// R3 - Forced low sends 111, high sends 000
// R4 - Defeat ignored in E3 or without C-bit parity
// R5 - Code drives subframe 4 C bits, error zeroes
// R6 - Control bit 14 enables payload loopback
// R7 - Loopback sends framed receive data to transmit
// R8 - Violation placed on next third consecutive one
// R9 - Excess zero suppresses next substitution codeword
// R10 - Violation and zero inserts off when unipolar
// R11 - Parity insert inverts both P bits, T3 only
// R12 - CP insert inverts three CP bits, C-bit T3
// R13 - Framing insert starts at next framing bit
// R14 - Type 00: one F error or word 1111000000
// R15 - Type 01: one M error or inverted word
// R16 - Type 10: four F errors or four words
// R17 - Type 11: three M errors, four inverted words
// R18 - Software clears and sets bit per error
// R19 - Register mode: each insert bit rise inserts
// R20 - Manual mode: pin rise inserts enabled types
// R21 - External party pulses manual pin per error
// R22 - Edges synchronised; requests pend until position occurs
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "tx_err_map.svh"
module t3e3_tx_error_insert
   import tx_err_pkg::*;
(
   input  wire logic        clock,                   // System clock, 125 MHz
   input  wire logic        rst_b,                   // Asynchronous reset, active low
   input  wire logic        ce,                      // Clock enable, freezes all state when low
   input  wire logic        wb_cyc_i,                // Wishbone cycle
   input  wire logic        wb_stb_i,                // Wishbone strobe
   input  wire logic        wb_we_i,                 // Wishbone write enable
   input  wire logic [7:0]  wb_adr_i,                // Wishbone byte address
   input  wire logic [3:0]  wb_sel_i,                // Wishbone byte lanes
   input  wire logic [31:0] wb_dat_i,                // Wishbone write data
   output logic      [31:0] wb_dat_o,                // Wishbone read data
   output logic             wb_ack_o,                // Wishbone acknowledge
   input  wire logic        line_clk,                // Transmit line clock pin
   input  wire logic        manual_error_insert_pin, // Manual error insert pin
   input  wire fmt_in_t     fmt_in,                  // Formatter stream and positions
   output line_out_t        line_out,                // Stream toward the encoder
   output logic             payload_loopback_active  // Payload loopback in force
);
   // All state sits in one packed struct behind a single register stage. The clock enable then
   // freezes every flop at once, synchronisers and bus handshake included.
   typedef struct packed {
      logic        ack;
      logic [31:0] rdat;
      logic        auto_block_error_defeat;
      logic        forced_block_error_setting;
      logic        payload_loopback_enable;
      logic [7:0]  eic;
      logic [4:0]  eic_prev;
      logic [2:0]  cfg;
      fmt_in_t     f1;
      fmt_in_t     f2;
      logic [2:0]  lck;
      logic [2:0]  pin;
      logic [4:0]  pend;
      logic        p_act;
      logic        cp_act;
      logic        fe_act;
      logic [2:0]  fe_cnt;
      logic [1:0]  fe_type;
      logic [1:0]  run;
      logic        rx_seen;
      logic        febe_err;
      line_out_t   out;
      logic        plb_out;
   } state_t;

   state_t s;
   state_t next_s;

   // Exact match on the byte address, so the unmapped holes never alias a live register.
   function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
      return adr == off;
   endfunction

   // Byte-lane merge for one lane of a register. A lane that is not selected keeps its old
   // contents, so a narrow write cannot disturb its neighbours.
   function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [31:0] wd, input logic [3:0] sel,
                                             input int lane);
      return sel[lane] ? wd[8*lane +: 8] : old;
   endfunction

   logic        req;
   logic        le;
   logic        pin_rise;
   logic        e3;
   logic        cbit;
   logic        unipolar;
   logic [4:0]  trig;
   logic [4:0]  allowed;
   logic [31:0] rd;
   logic [15:0] ctl_word;
   logic        d;
   logic        fe_start;
   logic        fe_pos;
   logic        fe_flip;
   logic        fe_dec;
   logic [2:0]  fe_len;
   logic        febe_zero;
   fmt_in_t     f;

   always_comb begin
      next_s = s;
      req = wb_cyc_i & wb_stb_i & ~s.ack;
      e3 = s.cfg[`CFG_E3_BIT];
      cbit = s.cfg[`CFG_CBIT_BIT];
      unipolar = s.cfg[`CFG_UNIPOLAR_BIT];
      f = s.f2;

      // Synchronisers: stage one feeds stage two only.
      // The formatter group is sampled as a whole; it holds for a full line bit, so no field skews.
      next_s.f1 = fmt_in; // R22
      next_s.f2 = s.f1;
      next_s.lck = {s.lck[1:0], line_clk};
      next_s.pin = {s.pin[1:0], manual_error_insert_pin};
      le = s.lck[1] & ~s.lck[2];
      pin_rise = s.pin[1] & ~s.pin[2]; // R22

      // Register bus. Every access is answered in the next cycle and never stalls; read data
      // is zero outside the acknowledge, so a late master cannot latch a stale word.
      next_s.ack = req;
      ctl_word = 16'h0000;
      ctl_word[`AUTO_BLOCK_ERROR_DEFEAT_BIT] = s.auto_block_error_defeat;
      ctl_word[`FORCED_BLOCK_ERROR_SETTING_BIT] = s.forced_block_error_setting;
      ctl_word[`PLB_BIT] = s.payload_loopback_enable;
      rd = `WORD_ZERO;
      if (hit(wb_adr_i, `ADR_FRAMER_CTRL)) begin
         rd = {16'h0000, ctl_word};
      end else if (hit(wb_adr_i, `ADR_ERR_INSERT)) begin
         rd = {24'h000000, s.eic};
      end else if (hit(wb_adr_i, `ADR_LINE_CFG)) begin
         rd = {29'h0000000, s.cfg};
      end else if (hit(wb_adr_i, `ADR_INSERT_STATUS)) begin
         rd = {20'h00000, s.febe_err, s.fe_cnt, s.fe_act, s.cp_act, s.p_act, s.pend};
      end
      next_s.rdat = req ? rd : `WORD_ZERO;
      if (req && wb_we_i) begin
         if (hit(wb_adr_i, `ADR_FRAMER_CTRL) && wb_sel_i[1]) begin
            next_s.auto_block_error_defeat = wb_dat_i[`AUTO_BLOCK_ERROR_DEFEAT_BIT];
            next_s.forced_block_error_setting = wb_dat_i[`FORCED_BLOCK_ERROR_SETTING_BIT];
            next_s.payload_loopback_enable = wb_dat_i[`PLB_BIT]; // R6
         end
         if (hit(wb_adr_i, `ADR_ERR_INSERT)) begin
            next_s.eic = lane_merge(s.eic, wb_dat_i, wb_sel_i, 0);
         end
         if (hit(wb_adr_i, `ADR_LINE_CFG) && wb_sel_i[0]) begin
            next_s.cfg = wb_dat_i[2:0];
         end
      end

      // Triggers: register rises, or pin rises gated by the enable bits.
      next_s.eic_prev = s.eic[4:0];
      if (s.eic[`MANUAL_BIT]) begin
         trig = pin_rise ? s.eic[4:0] : 5'h00; // R20 R21
      end else begin
         trig = s.eic[4:0] & ~s.eic_prev; // R19 R18
      end
      allowed = 5'h1F;
      allowed[`BPV_BIT] = ~unipolar; // R10
      allowed[`EXZ_BIT] = ~unipolar; // R10
      allowed[`PBIT_BIT] = ~e3; // R11
      allowed[`CPBIT_BIT] = ~e3 & cbit; // R12
      // A request that the current mode forbids is dropped here rather than held. A later mode
      // change therefore cannot release an old request. The pending bits are set at the end.
      // The framing type is taken when a framing trigger finds no framing request pending, so a trigger
      // during a burst also retypes the burst in progress.
      if (trig[`FBE_BIT] && !s.pend[`FBE_BIT]) begin
         next_s.fe_type = {s.eic[`FTYPE_MSB_BIT], s.eic[`FTYPE_LSB_BIT]};
      end

      // Line stream, advanced on each rising edge of the line clock.
      // Inserts act on looped-back data as well, so a loopback path can be exercised with errors.
      next_s.out.valid = le;
      next_s.plb_out = s.payload_loopback_enable;
      d = s.payload_loopback_enable ? f.rx_data : f.data; // R7
      fe_start = 1'b0;
      fe_pos = 1'b0;
      fe_flip = 1'b0;
      fe_dec = 1'b0;
      fe_len = `FE_COUNT_ONE;
      febe_zero = 1'b0;
      if (le) begin
         next_s.out.bpv = 1'b0;
         next_s.out.no_subst = 1'b0;

         // Violation goes on the third or any later one of a run.
         // The run counter saturates, so a long run of ones cannot wrap it back to zero.
         if (d) begin
            next_s.run = (s.run == `ONES_BEFORE_BPV) ? s.run : s.run + 2'h1;
         end else begin
            next_s.run = 2'h0;
         end
         if (s.pend[`BPV_BIT] && d && s.run == `ONES_BEFORE_BPV) begin
            next_s.out.bpv = 1'b1; // R8
            next_s.pend[`BPV_BIT] = 1'b0;
            next_s.run = 2'h0;
         end
         if (s.pend[`EXZ_BIT] && f.subst_ok) begin
            next_s.out.no_subst = 1'b1; // R9
            next_s.pend[`EXZ_BIT] = 1'b0;
         end

         // Parity inserts act over one whole frame so every P or CP bit flips.
         if (f.frame_start) begin
            next_s.p_act = s.pend[`PBIT_BIT]; // R11
            next_s.cp_act = s.pend[`CPBIT_BIT]; // R12
            next_s.pend[`PBIT_BIT] = 1'b0;
            next_s.pend[`CPBIT_BIT] = 1'b0;
         end
         if ((f.p_bit && (s.p_act || (f.frame_start && s.pend[`PBIT_BIT]))) ||
             (f.cp_bit && (s.cp_act || (f.frame_start && s.pend[`CPBIT_BIT])))) begin
            d = ~d; // R11 R12
         end

         // Framing errors: E3 starts only on a word boundary so words stay whole.
         if (e3) begin
            fe_pos = f.fas_bit;
            fe_start = f.fas_bit && f.fas_idx == `FAS_FIRST_IDX;
            fe_flip = s.fe_type[0] || f.fas_idx == `FAS_SINGLE_IDX; // R14 R15
            fe_dec = f.fas_bit && f.fas_idx == `FAS_LAST_IDX;
            fe_len = s.fe_type[1] ? `FE_COUNT_E3_BURST : `FE_COUNT_ONE; // R16 R17
         end else begin
            fe_pos = s.fe_type[0] ? f.m_bit : f.f_bit; // R14 R15
            fe_start = fe_pos;
            fe_flip = 1'b1;
            fe_dec = fe_pos;
            if (s.fe_type == 2'b10) begin
               fe_len = `FE_COUNT_F_BURST; // R16
            end else if (s.fe_type == 2'b11) begin
               fe_len = `FE_COUNT_M_BURST; // R17
            end
         end
         if (!s.fe_act && s.pend[`FBE_BIT] && fe_start) begin
            next_s.fe_act = 1'b1; // R13
            next_s.fe_cnt = fe_len;
            next_s.pend[`FBE_BIT] = 1'b0;
            if (fe_flip) begin
               d = ~d;
            end
            if (fe_dec && fe_len == `FE_COUNT_ONE) begin
               next_s.fe_act = 1'b0;
            end else if (fe_dec) begin
               next_s.fe_cnt = fe_len - 3'h1;
            end
         end else if (s.fe_act && fe_pos) begin
            if (fe_flip) begin
               d = ~d; // R13
            end
            if (fe_dec) begin
               next_s.fe_cnt = s.fe_cnt - 3'h1;
               next_s.fe_act = s.fe_cnt != `FE_COUNT_ONE;
            end
         end

         // Block error code: receive errors seen in one frame mark the next.
         // The latch clears at each frame start, so one error marks one frame only.
         next_s.rx_seen = s.rx_seen | f.rx_block_err;
         if (f.frame_start) begin
            next_s.febe_err = s.rx_seen | f.rx_block_err; // R1
            next_s.rx_seen = 1'b0;
         end
         if (s.auto_block_error_defeat && !e3 && cbit) begin
            febe_zero = s.forced_block_error_setting; // R2 R3 R4
         end else begin
            febe_zero = s.febe_err; // R1 R4
         end
         if (f.febe_bit && !e3 && cbit) begin
            d = ~febe_zero; // R5
         end
         next_s.out.data = d;
      end

      // Set after the clears above: a trigger that lands in the cycle that consumes an earlier
      // request of the same kind stays pending instead of being lost.
      next_s.pend = next_s.pend | (trig & allowed); // R22
   end

   // One register stage for all state. While the enable is low the whole block, synchronisers
   // included, keeps its picture of the inputs and resumes from it.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // Every output is a register field, so no combinational path reaches a pin.
   assign wb_dat_o = s.rdat;
   assign wb_ack_o = s.ack;
   assign line_out = s.out;
   assign payload_loopback_active = s.plb_out;
endmodule
`default_nettype wire

// ===== verif/line_partner.sv
// Purpose: Formatter and receive side stand-in feeding the block a framed stream.
// Assumes: 32-bit frame: F, M, two P, three CP, three block error and ten alignment bits.
// Notes:   The line clock runs free as a line does; fields change on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module line_partner
   import tx_err_pkg::*;
(
   input  wire logic blk_err,  // Receive errors
   output logic      line_clk, // Line clock
   output fmt_in_t   fmt       // Stream
);
   logic [4:0] pos;
   initial line_clk = 1'b0;
   initial pos = 5'h00;
   always #62.5 line_clk = ~line_clk;
   always @(negedge line_clk) pos <= pos + 5'h01;
   always_comb begin
      fmt = '0;
      fmt.data = pos[2:0] != 3'h3;
      fmt.rx_data = pos[0];
      fmt.subst_ok = pos[2:0] == 3'h3;
      fmt.f_bit = pos == 5'h00;
      fmt.frame_start = pos == 5'h00;
      fmt.m_bit = pos == 5'h04;
      fmt.p_bit = pos inside {5'h08, 5'h09};
      fmt.cp_bit = pos inside {[5'h0C:5'h0E]};
      fmt.febe_bit = pos inside {[5'h10:5'h12]};
      fmt.fas_bit = pos inside {[5'h14:5'h1D]};
      fmt.fas_idx = 4'(pos - 5'h14);
      fmt.rx_block_err = blk_err;
   end
endmodule
`default_nettype wire

// ===== verif/tx_err_monitor.sv
// Purpose: Port checker for the transmit error insert block.
// Assumes: No bus traffic while line bits are judged; checks pause after the clock enable drops.
// Notes:   Register copies lag the bus, so stream checks wait for a quiet bus.
`timescale 1ns/1ps
`default_nettype none
module tx_err_monitor
   import tx_err_pkg::*;
(
   input wire logic        clock,                  // Clock
   input wire logic        rst_b,                  // Reset
   input wire logic        ce,                     // Enable
   input wire logic        wb_cyc_i,               // Cycle
   input wire logic        wb_stb_i,               // Strobe
   input wire logic        wb_we_i,                // Write
   input wire logic [7:0]  wb_adr_i,               // Address
   input wire logic [3:0]  wb_sel_i,               // Lanes
   input wire logic [31:0] wb_dat_i,               // Write data
   input wire logic [31:0] wb_dat_o,               // Read data
   input wire logic        wb_ack_o,               // Ack
   input wire fmt_in_t     fmt_in,                 // Formatter
   input wire line_out_t   line_out,               // Line
   input wire logic        payload_loopback_active // Loopback
);
   logic [2:0] ctl;
   logic [2:0] cfg;
   logic [2:0] calm;
   logic       ok;
   logic       pick;
   logic       plain;
   assign ok = line_out.valid && calm == 3'h7;
   assign pick = ctl[2] ? fmt_in.rx_data : fmt_in.data;
   assign plain = !(fmt_in.f_bit || fmt_in.m_bit || fmt_in.p_bit || fmt_in.cp_bit || fmt_in.febe_bit || fmt_in.fas_bit);
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ctl <= 3'h0;
         cfg <= 3'h0;
         calm <= 3'h0;
      end else begin
         if (wb_ack_o && wb_we_i && wb_adr_i == 8'h10 && wb_sel_i[1]) ctl <= wb_dat_i[14:12];
         if (wb_ack_o && wb_we_i && wb_adr_i == 8'h1C && wb_sel_i[0]) cfg <= wb_dat_i[2:0];
         calm <= (wb_cyc_i && wb_stb_i || !ce) ? 3'h0 : calm + {2'h0, calm != 3'h7};
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   property p_ack_next; ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack missing");
   property p_dat_quiet; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   a_dat_quiet: assert property (p_dat_quiet) else $error("read data outside ack");
   property p_valid_pulse; line_out.valid |=> !line_out.valid [*8]; endproperty
   a_valid_pulse: assert property (p_valid_pulse) else $error("line strobe too close");
   property p_loop_copy; calm == 3'h7 |-> payload_loopback_active == ctl[2]; endproperty
   a_loop_copy: assert property (p_loop_copy) else $error("loopback flag wrong");
   property p_loop_data; ok && plain |-> line_out.data == pick; endproperty
   a_loop_data: assert property (p_loop_data) else $error("payload source wrong");
   property p_febe_forced; ok && fmt_in.febe_bit && ctl[0] && cfg[1:0] == 2'h2 |-> line_out.data == !ctl[1]; endproperty
   a_febe_forced: assert property (p_febe_forced) else $error("forced code wrong");
   property p_febe_off; ok && fmt_in.febe_bit && cfg[1:0] != 2'h2 |-> line_out.data == pick; endproperty
   a_febe_off: assert property (p_febe_off) else $error("code bit altered");
   property p_unipolar; ok && cfg[2] |-> !line_out.bpv && !line_out.no_subst; endproperty
   a_unipolar: assert property (p_unipolar) else $error("insert while unipolar");
   property p_exz_spot; line_out.valid && line_out.no_subst |-> fmt_in.subst_ok; endproperty
   a_exz_spot: assert property (p_exz_spot) else $error("skip off codeword");
   c_bpv: cover property (line_out.valid && line_out.bpv);
   c_skip: cover property (line_out.valid && line_out.no_subst);
   c_loop: cover property (ok && ctl[2]);
endmodule
bind t3e3_tx_error_insert tx_err_monitor u_tx_err_monitor (.clock(clock), .rst_b(rst_b), .ce(ce),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fmt_in(fmt_in), .line_out(line_out),
   .payload_loopback_active(payload_loopback_active));
`default_nettype wire

// ===== verif/t3e3_tx_error_insert_tb_top.sv
// Purpose: Self-checking bench for the transmit error insert block.
// Assumes: 32-bit partner frame; each trial watches six frames.
// Notes:   Counts line bits that differ from the formatter bit, violations and skipped codewords.
`timescale 1ns/1ps
`default_nettype none
module t3e3_tx_error_insert_tb_top import tx_err_pkg::*;;
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic        ce = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        line_clk;
   logic        manual_error_insert_pin = 1'b0;
   logic        blk_err = 1'b0;
   logic        payload_loopback_active;
   fmt_in_t     fmt_in;
   line_out_t   line_out;
   logic [31:0] seed = 32'h0001_0EAD;
   int          bad_count = 0;
   int          checks_done = 0;
   logic [7:0]  adrs [4] = '{8'h10, 8'h18, 8'h1C, 8'h04};
   logic [31:0] masks [4] = '{32'h0000_7000, 32'h0000_00FF, 32'h0000_0007, 32'h0};
   always #4 clock = ~clock;
   t3e3_tx_error_insert u_t3e3_tx_error_insert (.clock(clock), .rst_b(rst_b), .ce(ce), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .line_clk(line_clk), .manual_error_insert_pin(manual_error_insert_pin),
      .fmt_in(fmt_in), .line_out(line_out), .payload_loopback_active(payload_loopback_active));
   line_partner u_line_partner (.blk_err(blk_err), .line_clk(line_clk), .fmt(fmt_in));
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic timeout;
      bad_count++;
      $display("BAD wait expected answer seen none");
      final_report();
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic int exp_flips(input logic e3, input logic [1:0] t);
      if (e3) return (t[0] ? 10 : 1) * (t[1] ? 4 : 1);
      return t[1] ? (t[0] ? 3 : 4) : 1;
   endfunction
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clock);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) timeout();
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clock);
   endtask
   task automatic watch(output int f, output int b, output int n);
      int k;
      int got;
      k = 0;
      got = 0;
      f = 0;
      b = 0;
      n = 0;
      while (got < 192 && k < 4000) begin
         @(posedge clock);
         k++;
         if (line_out.valid === 1'b1) begin
            got++;
            f += int'(line_out.data !== fmt_in.data);
            b += int'(line_out.bpv);
            n += int'(line_out.no_subst);
         end
      end
      if (got < 192) timeout();
   endtask
   task automatic trial(input logic [2:0] cfg, input logic [2:0] ctl, input logic [7:0] eic, input logic clr,
                        input logic pin, input int ef, input int eb, input int en);
      logic [31:0] q;
      int          f;
      int          b;
      int          n;
      wb(1'b1, 8'h1C, {29'h0, cfg}, q);
      wb(1'b1, 8'h10, {17'h0, ctl, 12'h000}, q);
      if (clr) wb(1'b1, 8'h18, {24'h0, eic & 8'hE0}, q);
      wb(1'b1, 8'h18, {24'h0, eic}, q);
      if (pin) begin
         manual_error_insert_pin <= 1'b1;
         repeat (4) @(posedge clock);
         manual_error_insert_pin <= 1'b0;
      end
      watch(f, b, n);
      check("flipped bits", f, ef);
      check("violations", b, eb);
      check("skipped codewords", n, en);
      $display("trial done cfg %b ctl %b eic %h", cfg, ctl, eic);
   endtask
   initial begin
      logic [31:0] q;
      int          f;
      int          b;
      int          n;
      int          k;
      repeat (12) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      for (int i = 0; i < 4; i++) begin
         wb(1'b0, adrs[i], 32'h0, q);
         check("reset value", q, 32'h0);
         seed = lfsr(seed);
         wb(1'b1, adrs[i], seed, q);
         wb(1'b0, adrs[i], 32'h0, q);
         check("readback", q, seed & masks[i]);
         wb(1'b1, adrs[i], 32'h0, q);
      end
      repeat (3000) @(posedge clock);
      wb(1'b1, 8'h10, 32'h0000_4000, q);
      check("loopback on", {31'h0, payload_loopback_active}, 32'h1);
      watch(f, b, n);
      wb(1'b1, 8'h10, 32'h0, q);
      check("loopback off", {31'h0, payload_loopback_active}, 32'h0);
      // Freeze just after a line strobe; a live block would strobe two or three times in 40 cycles.
      k = 0;
      while (line_out.valid !== 1'b1 && k < 40) begin
         @(posedge clock);
         k++;
      end
      if (line_out.valid !== 1'b1) timeout();
      @(posedge clock);
      ce <= 1'b0;
      n = 0;
      repeat (40) begin
         @(posedge clock);
         n += int'(line_out.valid === 1'b1);
      end
      ce <= 1'b1;
      check("strobes while frozen", n, 0);
      $display("registers done");
      trial(3'h2, 3'h0, 8'h01, 1'b1, 1'b0, 0, 1, 0);
      trial(3'h2, 3'h0, 8'h01, 1'b0, 1'b0, 0, 0, 0);
      trial(3'h6, 3'h0, 8'h01, 1'b1, 1'b0, 0, 0, 0);
      trial(3'h2, 3'h0, 8'h02, 1'b1, 1'b0, 0, 0, 1);
      trial(3'h2, 3'h0, 8'h04, 1'b1, 1'b0, 2, 0, 0);
      trial(3'h1, 3'h0, 8'h04, 1'b1, 1'b0, 0, 0, 0);
      trial(3'h2, 3'h0, 8'h08, 1'b1, 1'b0, 3, 0, 0);
      trial(3'h0, 3'h0, 8'h08, 1'b1, 1'b0, 0, 0, 0);
      for (int i = 0; i < 8; i++) begin
         trial(i[2] ? 3'h1 : 3'h2, 3'h0, 8'h10 | {1'b0, i[1:0], 5'h00}, 1'b1, 1'b0, exp_flips(i[2], i[1:0]), 0, 0);
      end
      trial(3'h2, 3'h0, 8'h81, 1'b1, 1'b1, 0, 1, 0);
      trial(3'h2, 3'h0, 8'h80, 1'b1, 1'b1, 0, 0, 0);
      blk_err <= 1'b1;
      repeat (1200) @(posedge clock);
      trial(3'h2, 3'h0, 8'h00, 1'b1, 1'b0, 18, 0, 0);
      trial(3'h2, 3'h1, 8'h00, 1'b1, 1'b0, 0, 0, 0);
      trial(3'h2, 3'h3, 8'h00, 1'b1, 1'b0, 18, 0, 0);
      trial(3'h1, 3'h3, 8'h00, 1'b1, 1'b0, 0, 0, 0);
      trial(3'h0, 3'h3, 8'h00, 1'b1, 1'b0, 0, 0, 0);
      final_report();
   end
endmodule
`default_nettype wire
